// *** rtl/ccr_pkg.sv ***
package ccr_pkg;

  // Pin, counter and accumulator widths and the position of the bus clock in the synchroniser
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned SYNC_W  = SEL_W + 1;
  localparam int unsigned BUS_BIT = SEL_W;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned ACC_W   = 20;

  // Cycles the pin synchroniser needs before the select is trusted
  localparam logic [CNT_W-1:0] SETTLE_CYC = 16'h0004;
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;

  // Select codes
  localparam logic [SEL_W-1:0] SEL_2X_OSC2 = 4'h4;
  localparam logic [SEL_W-1:0] SEL_2X_OSC4 = 4'h5;
  localparam logic [SEL_W-1:0] SEL_2P5X    = 4'h6;
  localparam logic [SEL_W-1:0] SEL_3X      = 4'h8;
  localparam logic [SEL_W-1:0] SEL_3P5X    = 4'he;
  localparam logic [SEL_W-1:0] SEL_4X      = 4'ha;
  localparam logic [SEL_W-1:0] SEL_4P5X    = 4'h7;
  localparam logic [SEL_W-1:0] SEL_5X      = 4'hb;
  localparam logic [SEL_W-1:0] SEL_5P5X    = 4'h9;
  localparam logic [SEL_W-1:0] SEL_6X      = 4'hd;
  localparam logic [SEL_W-1:0] SEL_BYPASS  = 4'h3;
  localparam logic [SEL_W-1:0] SEL_OFF     = 4'hf;

  // Bus-to-core multiplier in half steps (4 means 2x)
  localparam logic [3:0] MULT_H_1TO1 = 4'h2;
  localparam logic [3:0] MULT_H_2X   = 4'h4;
  localparam logic [3:0] MULT_H_2P5X = 4'h5;
  localparam logic [3:0] MULT_H_3X   = 4'h6;
  localparam logic [3:0] MULT_H_3P5X = 4'h7;
  localparam logic [3:0] MULT_H_4X   = 4'h8;
  localparam logic [3:0] MULT_H_4P5X = 4'h9;
  localparam logic [3:0] MULT_H_5X   = 4'ha;
  localparam logic [3:0] MULT_H_5P5X = 4'hb;
  localparam logic [3:0] MULT_H_6X   = 4'hc;
  localparam logic [3:0] MULT_H_NONE = 4'h0;

  // Core-to-oscillator multiplier
  localparam logic [2:0] OSC_2X   = 3'h2;
  localparam logic [2:0] OSC_4X   = 3'h4;
  localparam logic [2:0] OSC_NONE = 3'h0;

  typedef enum logic [1:0] {
    MODE_RATIO  = 2'b00,
    MODE_BYPASS = 2'b01,
    MODE_OFF    = 2'b10
  } ccr_mode_t;

  typedef struct packed {
    ccr_mode_t  mode;
    logic [3:0] mult_h;
    logic [2:0] osc_mult;
  } ccr_cfg_t;

  localparam ccr_cfg_t CFG_RESET = '{MODE_OFF, MULT_H_NONE, OSC_NONE};

  // Clock outputs and lock status
  typedef struct packed {
    logic core_tick;
    logic osc_tick;
    logic locked;
  } ccr_tick_t;

  typedef enum logic [2:0] {
    ST_SETTLE  = 3'b000,
    ST_CAPTURE = 3'b001,
    ST_FIRST   = 3'b010,
    ST_MEASURE = 3'b011,
    ST_RUN     = 3'b100,
    ST_OFF     = 3'b101
  } ccr_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
  } ccr_sync_t;

  typedef struct packed {
    ccr_state_t       st;
    ccr_cfg_t         cfg;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic [ACC_W-1:0] acc_core;
    logic [ACC_W-1:0] acc_osc;
    logic             bus_prev;
    logic             core_tick;
    logic             osc_tick;
    logic             locked;
  } ccr_core_t;

  // Select code to mode and ratios; unassigned codes fall to clock-off
  function automatic ccr_cfg_t ccr_decode(input logic [SEL_W-1:0] sel);
    ccr_cfg_t c;
    c = CFG_RESET;
    unique case (sel)
      SEL_2X_OSC2: c = '{MODE_RATIO, MULT_H_2X, OSC_2X};
      SEL_2X_OSC4: c = '{MODE_RATIO, MULT_H_2X, OSC_4X};
      SEL_2P5X:    c = '{MODE_RATIO, MULT_H_2P5X, OSC_2X};
      SEL_3X:      c = '{MODE_RATIO, MULT_H_3X, OSC_2X};
      SEL_3P5X:    c = '{MODE_RATIO, MULT_H_3P5X, OSC_2X};
      SEL_4X:      c = '{MODE_RATIO, MULT_H_4X, OSC_2X};
      SEL_4P5X:    c = '{MODE_RATIO, MULT_H_4P5X, OSC_2X};
      SEL_5X:      c = '{MODE_RATIO, MULT_H_5X, OSC_2X};
      SEL_5P5X:    c = '{MODE_RATIO, MULT_H_5P5X, OSC_2X};
      SEL_6X:      c = '{MODE_RATIO, MULT_H_6X, OSC_2X};
      SEL_BYPASS:  c = '{MODE_BYPASS, MULT_H_1TO1, OSC_NONE};
      default:     c = CFG_RESET;
    endcase
    return c;
  endfunction : ccr_decode

endpackage : ccr_pkg

// *** rtl/ccr_pin_sync.sv ***
`timescale 1ns/100ps

module ccr_pin_sync (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rstn,
  // Raw pins and filtered levels
  input  wire logic [ccr_pkg::SYNC_W-1:0] i_pins,
  output logic      [ccr_pkg::SYNC_W-1:0] o_levels
);
  import ccr_pkg::*;

  ccr_sync_t         r;
  ccr_sync_t         nxt;
  logic [SYNC_W-1:0] filt_nxt;

  // Per-bit agreement filter, so a metastable third stage never leaks out
  for (genvar b = 0; b < SYNC_W; b++) begin : g_agree
    assign filt_nxt[b] = (r.s2[b] == r.s3[b]) ? r.s3[b] : r.filt[b];
  end

  // Three stages; a bit moves only when stages two and three agree
  always_comb begin
    nxt      = r;
    nxt.s1   = i_pins;
    nxt.s2   = r.s1;
    nxt.s3   = r.s2;
    nxt.filt = filt_nxt;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign o_levels = r.filt;

endmodule : ccr_pin_sync

// *** rtl/ccr_ratio_select.sv ***
`timescale 1ns/100ps

// Functional notes
// - Core and oscillator ticks are derived from the bus clock at the ratio that the select sets.
// - Code 0100 gives core 2x bus with oscillator 2x core, code 0101 gives core 2x with osc 4x.
// - Codes 0110/1000/1110/1010/0111/1011/1001/1101 give 2.5x to 6x core, oscillator 2x core.
// - Code 0011 disables the loop and the bus clock drives the core ticks directly.
// - In bypass the bus interface runs at one bus clock per core clock.
// - Code 1111 stops all core and oscillator ticks whatever the bus clock does.
module ccr_ratio_select (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  // Pins from the board
  input  wire logic                     i_bus_clock_in,
  input  wire logic [ccr_pkg::SEL_W-1:0] i_ratio_sel,
  // Derived clocking
  output ccr_pkg::ccr_tick_t            o_ticks,
  output ccr_pkg::ccr_cfg_t             o_cfg,
  output logic                          o_bus_1to1
);
  import ccr_pkg::*;

  logic [SYNC_W-1:0] levels;
  ccr_core_t         r;
  ccr_core_t         nxt;

  // Both pins come from the board, outside this clock domain
  ccr_pin_sync u_sync (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_pins   ({i_bus_clock_in, i_ratio_sel}),
    .o_levels (levels)
  );

  // Phase accumulators spread ticks evenly over one measured bus period.
  // Limitation: at most one tick per i_clk, so fast products saturate.
  always_comb begin
    logic             bus;
    logic             bus_rise;
    logic [ACC_W-1:0] thr;
    logic [ACC_W-1:0] step_core;
    logic [ACC_W-1:0] step_osc;
    logic [ACC_W-1:0] a_core;
    logic [ACC_W-1:0] a_osc;
    logic [6:0]       osc_step;
    bus       = levels[BUS_BIT];
    bus_rise  = bus & ~r.bus_prev;
    thr       = {3'h0, r.period, 1'b0};
    // Widen before multiplying; a 4-bit product would wrap at 4x oscillator
    osc_step  = 7'(r.cfg.mult_h) * 7'(r.cfg.osc_mult);
    step_core = {16'h0, r.cfg.mult_h};
    step_osc  = {13'h0, osc_step};
    a_core    = r.acc_core + step_core;
    a_osc     = r.acc_osc + step_osc;
    nxt           = r;
    nxt.bus_prev  = bus;
    nxt.core_tick = 1'b0;
    nxt.osc_tick  = 1'b0;
    unique case (r.st)
      // Let the synchroniser fill before trusting the select
      ST_SETTLE: begin
        nxt.cnt = r.cnt + 16'h0001;
        if (r.cnt == SETTLE_CYC - 16'h0001) begin
          nxt.st  = ST_CAPTURE;
          nxt.cnt = '0;
        end
      end
      // Single capture; the select is never looked at again
      ST_CAPTURE: begin
        nxt.cfg = ccr_decode(levels[SEL_W-1:0]);
        unique case (nxt.cfg.mode)
          MODE_OFF: begin
            nxt.st = ST_OFF;
          end
          MODE_BYPASS: begin
            nxt.st     = ST_RUN;
            nxt.locked = 1'b1;
          end
          MODE_RATIO: begin
            nxt.st = ST_FIRST;
          end
          default: begin
            nxt.st = ST_OFF;
          end
        endcase
      end
      // Wait for the first bus edge to start a period measurement
      ST_FIRST: begin
        if (bus_rise) begin
          nxt.cnt = '0;
          nxt.st  = ST_MEASURE;
        end
      end
      // Measure one bus period, then declare lock
      ST_MEASURE: begin
        if (r.cnt != CNT_MAX) begin
          nxt.cnt = r.cnt + 16'h0001;
        end
        if (bus_rise) begin
          nxt.period   = r.cnt + 16'h0001;
          nxt.cnt      = '0;
          nxt.acc_core = '0;
          nxt.acc_osc  = '0;
          nxt.locked   = 1'b1;
          nxt.st       = ST_RUN;
        end
      end
      ST_RUN: begin
        if (r.cfg.mode == MODE_BYPASS) begin
          nxt.core_tick = bus_rise;
        end else begin
          // Keep tracking the bus period so slow drift is followed
          if (r.cnt != CNT_MAX) begin
            nxt.cnt = r.cnt + 16'h0001;
          end
          if (bus_rise) begin
            nxt.period = r.cnt + 16'h0001;
            nxt.cnt    = '0;
          end
          // mult_h/2 core ticks per bus period
          if (a_core >= thr) begin
            nxt.core_tick = 1'b1;
            nxt.acc_core  = a_core - thr;
          end else begin
            nxt.acc_core = a_core;
          end
          // Oscillator at osc_mult times the core rate
          if (a_osc >= thr) begin
            nxt.osc_tick = 1'b1;
            nxt.acc_osc  = a_osc - thr;
          end else begin
            nxt.acc_osc = a_osc;
          end
        end
      end
      // Nothing toggles, regardless of bus clock activity
      ST_OFF: begin
        nxt.core_tick = 1'b0;
        nxt.osc_tick  = 1'b0;
      end
      default: begin
        nxt.st = ST_OFF;
      end
    endcase
  end

  // All state in one register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r          <= '0;
      r.st       <= ST_SETTLE;
      r.cfg      <= CFG_RESET;
    end else begin
      r <= nxt;
    end
  end

  assign o_ticks    = '{r.core_tick, r.osc_tick, r.locked};
  assign o_cfg      = r.cfg;
  assign o_bus_1to1 = (r.cfg.mode == MODE_BYPASS);

endmodule : ccr_ratio_select

// *** verification/ccr_ratio_select_assertions.sv ***
`timescale 1ns/100ps

module ccr_ratio_select_assertions (
  // Clock and reset
  input wire logic              i_clk,
  input wire logic              i_rstn,
  // Watched pins
  input wire logic              i_bus_clock_in,
  input wire ccr_pkg::ccr_tick_t o_ticks,
  input wire ccr_pkg::ccr_cfg_t  o_cfg,
  input wire logic              o_bus_1to1
);
  import ccr_pkg::*;

  // Bounds assume a bus period of at most 40 cycles
  localparam int TICK_MAX = 24;
  localparam int OSC_MAX  = 12;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Bus rise seen while bypass is chosen
  sequence s_byp_rise;
    o_cfg.mode == MODE_BYPASS && $rose(i_bus_clock_in);
  endsequence
  // Locked ratio run with a core tick
  sequence s_ratio_tick;
    o_cfg.mode == MODE_RATIO && o_ticks.locked && o_ticks.core_tick;
  endsequence

  property p_cfg_hold; o_cfg != CFG_RESET |=> $stable(o_cfg); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
  property p_off_quiet; o_cfg.mode == MODE_OFF |-> o_ticks == '0; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("ticks when off");
  property p_byp_flag; o_bus_1to1 == (o_cfg.mode == MODE_BYPASS); endproperty
  a_byp_flag: assert property (p_byp_flag) else $error("1to1 flag wrong");
  property p_byp_lock;
    o_cfg.mode == MODE_BYPASS |-> o_ticks.locked && !o_ticks.osc_tick
      && o_cfg.mult_h == MULT_H_1TO1;
  endproperty
  a_byp_lock: assert property (p_byp_lock) else $error("bypass state wrong");
  property p_byp_tick; s_byp_rise |-> ##[1:8] o_ticks.core_tick; endproperty
  a_byp_tick: assert property (p_byp_tick) else $error("bypass tick missing");
  property p_byp_single;
    o_cfg.mode == MODE_BYPASS && o_ticks.core_tick |=> !o_ticks.core_tick [*8];
  endproperty
  a_byp_single: assert property (p_byp_single) else $error("bypass ticks too fast");
  property p_ratio_tick;
    o_cfg.mode == MODE_RATIO && o_ticks.locked |-> ##[0:TICK_MAX] o_ticks.core_tick;
  endproperty
  a_ratio_tick: assert property (p_ratio_tick) else $error("core tick missing");
  property p_osc_tick; s_ratio_tick |-> ##[0:OSC_MAX] o_ticks.osc_tick; endproperty
  a_osc_tick: assert property (p_osc_tick) else $error("osc tick missing");
  property p_tick_locked;
    o_ticks.core_tick || o_ticks.osc_tick |-> o_ticks.locked;
  endproperty
  a_tick_locked: assert property (p_tick_locked) else $error("tick before lock");
endmodule : ccr_ratio_select_assertions

bind ccr_ratio_select ccr_ratio_select_assertions u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_bus_clock_in(i_bus_clock_in),
  .o_ticks(o_ticks), .o_cfg(o_cfg), .o_bus_1to1(o_bus_1to1));

// *** verification/ccr_board_model.sv ***
`timescale 1ns/100ps

module ccr_board_model #(
  parameter int HALF = 20
) (
  // Clock
  input  wire logic       i_clk,
  // Strap value wanted by the bench
  input  wire logic [3:0] i_sel_req,
  // Pins toward the device
  output logic            o_bus_clock_in,
  output logic [3:0]      o_ratio_sel
);
  int         cnt   = 0;
  logic       bus_r = 1'b0;
  logic [3:0] sel_r = 4'h0;

  // Free-running bus clock; slow enough that every result stays in range
  always @(posedge i_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) bus_r <= ~bus_r;
  end
  // Straps follow the request; the bench moves them around reset and once after lock in t_sel_change
  always @(posedge i_clk) sel_r <= i_sel_req;

  assign o_bus_clock_in = bus_r;
  assign o_ratio_sel    = sel_r;
endmodule : ccr_board_model

// *** verification/ccr_ratio_select_tb.sv ***
`timescale 1ns/100ps

module ccr_ratio_select_tb;
  import ccr_pkg::*;

  logic      i_clk;
  logic      i_rstn;
  logic      bus_clk;
  logic      bus_1to1;
  logic [3:0] sel_req;
  logic [3:0] sel;
  ccr_tick_t ticks;
  ccr_cfg_t  cfg;
  int        failures = 0;
  int        n_compared = 0;
  int        n_core;
  int        n_osc;

  ccr_board_model board (.i_clk(i_clk), .i_sel_req(sel_req), .o_bus_clock_in(bus_clk),
    .o_ratio_sel(sel));
  ccr_ratio_select uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus_clock_in(bus_clk),
    .i_ratio_sel(sel), .o_ticks(ticks), .o_cfg(cfg), .o_bus_1to1(bus_1to1));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Expected setting per select code, in half steps
  function automatic ccr_cfg_t exp_cfg(input logic [3:0] c);
    case (c)
      4'h4: return '{MODE_RATIO, 4'h4, 3'h2};
      4'h5: return '{MODE_RATIO, 4'h4, 3'h4};
      4'h6: return '{MODE_RATIO, 4'h5, 3'h2};
      4'h8: return '{MODE_RATIO, 4'h6, 3'h2};
      4'he: return '{MODE_RATIO, 4'h7, 3'h2};
      4'ha: return '{MODE_RATIO, 4'h8, 3'h2};
      4'h7: return '{MODE_RATIO, 4'h9, 3'h2};
      4'hb: return '{MODE_RATIO, 4'ha, 3'h2};
      4'h9: return '{MODE_RATIO, 4'hb, 3'h2};
      4'hd: return '{MODE_RATIO, 4'hc, 3'h2};
      4'h3: return '{MODE_BYPASS, 4'h2, 3'h0};
      default: return '{MODE_OFF, 4'h0, 3'h0};
    endcase
  endfunction : exp_cfg

  task automatic report_and_stop;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check_state(input ccr_cfg_t e, input logic lk);
    n_compared++;
    if ({cfg, bus_1to1, ticks.locked} !== {e, e.mode == MODE_BYPASS, lk}) begin
      failures++;
      $display("Error %0t: state %h", $time, {cfg, bus_1to1, ticks.locked});
    end
  endtask : check_state

  task automatic check_count(input int got, input int e, input int tol);
    n_compared++;
    if (got < e - tol || got > e + tol) begin
      failures++;
      $display("Error %0t: count %0d want %0d", $time, got, e);
    end
  endtask : check_count

  // Strap a code, pulse reset, then wait for lock within a bound
  task automatic start(input logic [3:0] c);
    @(posedge i_clk);
    sel_req <= c;
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 200 && ticks.locked !== 1'b1; i++) begin
      @(posedge i_clk);
      #1;
    end
  endtask : start

  // Ticks over four bus periods
  task automatic measure;
    n_core = 0;
    n_osc = 0;
    repeat (160) begin
      @(posedge i_clk);
      #1;
      n_core += int'(ticks.core_tick === 1'b1);
      n_osc += int'(ticks.osc_tick === 1'b1);
    end
  endtask : measure

  task automatic t_ratio_codes;
    logic [3:0] codes[10] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'he, 4'ha, 4'h7, 4'hb, 4'h9, 4'hd};
    ccr_cfg_t   e;
    foreach (codes[i]) begin
      e = exp_cfg(codes[i]);
      start(codes[i]);
      check_state(e, 1'b1);
      measure();
      check_count(n_core, 2 * int'(e.mult_h), 1);
      check_count(n_osc, 2 * int'(e.mult_h) * int'(e.osc_mult), 1);
    end
  endtask : t_ratio_codes

  // Factory-only mode, exercised here on purpose
  task automatic t_bypass;
    start(4'h3);
    check_state(exp_cfg(4'h3), 1'b1);
    measure();
    check_count(n_core, 4, 1);
    check_count(n_osc, 0, 0);
  endtask : t_bypass

  // Clock-off and reserved codes with the bus clock still running
  task automatic t_off_codes;
    logic [3:0] codes[5] = '{4'hf, 4'h0, 4'h1, 4'h2, 4'hc};
    foreach (codes[i]) begin
      start(codes[i]);
      check_state(exp_cfg(codes[i]), 1'b0);
      measure();
      check_count(n_core + n_osc, 0, 0);
    end
  endtask : t_off_codes

  // Straps moved after capture must be ignored
  task automatic t_sel_change;
    start(4'ha);
    sel_req <= 4'h3;
    measure();
    check_state(exp_cfg(4'ha), 1'b1);
    check_count(n_core, 16, 1);
  endtask : t_sel_change

  initial begin
    i_rstn = 1'b0;
    sel_req = 4'h0;
    t_ratio_codes();
    t_bypass();
    t_off_codes();
    t_sel_change();
    report_and_stop();
  end

  // Watchdog well beyond the roughly 5000 cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
endmodule : ccr_ratio_select_tb
